// File: rs3_pkg.sv
// Package: register map, field layout, reset values and timing for rail 3
package rs3_pkg;
    // Register offsets
    localparam logic [7:0] RS3_ACTIVE_OFS = 8'h2F;
    localparam logic [7:0] RS3_SLEEP_OFS = 8'h30;
    localparam logic [7:0] RS3_ON_DLY_OFS = 8'h31;
    localparam logic [7:0] RS3_OFF_DLY_OFS = 8'h32;
    localparam logic [7:0] RS3_SLEW_OFS = 8'h33;
    localparam logic [7:0] RS3_PHASE_OFS = 8'h34;
    // Implemented bits per register
    localparam logic [7:0] RS3_SET_MASK = 8'h3F;
    localparam logic [7:0] RS3_DLY_MASK = 8'h7F;
    localparam logic [7:0] RS3_SLEW_MASK = 8'hFF;
    localparam logic [7:0] RS3_PHASE_MASK = 8'h60;
    // Values held until the nonvolatile image is loaded
    localparam logic [7:0] RS3_ACTIVE_RST = 8'h00;
    localparam logic [7:0] RS3_SLEEP_RST = 8'h00;
    localparam logic [7:0] RS3_ON_DLY_RST = 8'h02;
    localparam logic [7:0] RS3_OFF_DLY_RST = 8'h3C;
    localparam logic [7:0] RS3_SLEW_RST = 8'h00;
    localparam logic [7:0] RS3_PHASE_RST = 8'h00;
    // Field positions
    localparam int RS3_MODE_LSB = 4;
    localparam int RS3_VOLT_LSB = 0;
    localparam int RS3_SOFT_LSB = 6;
    localparam int RS3_SHUT_LSB = 4;
    localparam int RS3_RUP_LSB = 2;
    localparam int RS3_RDN_LSB = 0;
    localparam int RS3_PH_LSB = 5;
    // Operating modes and shutdown option
    localparam logic [1:0] RS3_MODE_AUTO = 2'h0;
    localparam logic [1:0] RS3_MODE_FPWM = 2'h1;
    localparam logic [1:0] RS3_SHUT_OPT_SKIP = 2'h3;
    // Timing: delays and periods are counted in half-millisecond ticks
    localparam int RS3_CLK_PERIOD_NS = 10;
    localparam int RS3_HALF_MS_NS = 500000;
    localparam int RS3_HALF_MS_CYCLES = RS3_HALF_MS_NS / RS3_CLK_PERIOD_NS;
    localparam logic [8:0] RS3_SHUT_4MS = 9'h008;
    localparam logic [8:0] RS3_SHUT_2MS = 9'h004;
    localparam logic [8:0] RS3_SHUT_1MS = 9'h002;
    localparam logic [8:0] RS3_SHUT_0P5MS = 9'h001;
    typedef enum logic [2:0] {
        RS3_OFF, RS3_ON_WAIT, RS3_ON, RS3_OFF_WAIT,
        RS3_LAST_WAIT, RS3_SHUTDOWN, RS3_STANDBY, RS3_RESET
    } rs3_state_t;
endpackage

// File: rs3_timer.sv
// Half-millisecond tick timer with a programmable count of ticks
`timescale 1ns/1ns
`default_nettype none
module rs3_timer import rs3_pkg::*; #(
    parameter int HALF_MS_CYCLES = RS3_HALF_MS_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [8:0] ticks_i,
    output logic done_o
);
    logic [16:0] div_q, div_d;
    logic [8:0] cnt_q, cnt_d;
    logic run_q, run_d;
    logic done_q, done_d;

    always_comb begin
        div_d = div_q;
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (start_i) begin
            div_d = '0;
            cnt_d = '0;
            run_d = 1'b1;
        end else if (stop_i) begin
            run_d = 1'b0;
        end else if (run_q) begin
            if (cnt_q == ticks_i) begin
                done_d = 1'b1;
                run_d = 1'b0;
            end else if (div_q == 17'(HALF_MS_CYCLES - 1)) begin
                div_d = '0;
                cnt_d = cnt_q + 9'h001;
            end else begin
                div_d = div_q + 17'h00001;
            end
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            div_q <= '0;
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            div_q <= div_d;
            cnt_q <= cnt_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;
endmodule
`default_nettype wire

// File: rs3_sequencer.sv
// Rail 3 configuration registers and power sequencing controller
//
// Notes on behaviour
// - Awake mode field: 00 automatic pulse-frequency/width, 01 forced width.
// - Awake voltage code drives the target in the awake state; default 0.
// - Low-power mode field uses the same coding, applied in sleep.
// - Low-power voltage code drives the target in sleep; default 0.
// - Turn-on and turn-off delays count 0 to 127 ms from sequence start.
// - Soft-start code selects 4, 2, 1 or 0.5 ms.
// - Shutdown period code selects 4, 2, 1 or 0.5 ms.
// - Shutdown period applies when the shutdown option is 00, 01 or 10.
// - After enable falls, the period counts from the last rail off.
// - When the period ends, go to standby and then to reset.
// - Ramp-up code selects 2, 4, 8 or 16 mV per microsecond.
// - Ramp-down code uses the same slew encoding.
// - Phase shift code applies only while rail 1 phase lock is enabled.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module rs3_sequencer import rs3_pkg::*; #(
    parameter int HALF_MS_CYCLES = RS3_HALF_MS_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [7:0] rdata_o,
    input wire logic [47:0] nvm_image_i,
    input wire logic chip_enable_input_i,
    input wire logic sleep_state_i,
    input wire logic last_rail_off_i,
    input wire logic [1:0] shutdown_option_i,
    input wire logic rail1_phase_lock_enable_i,
    output logic rail3_enable_o,
    output logic [1:0] rail3_op_mode_o,
    output logic [3:0] rail3_voltage_code_o,
    output logic [1:0] rail3_soft_start_time_o,
    output logic [1:0] rail3_ramp_up_rate_o,
    output logic [1:0] rail3_ramp_down_rate_o,
    output logic [1:0] rail3_phase_shift_o,
    output logic fsm_standby_o,
    output logic fsm_reset_o
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] act_q, act_d, slp_q, slp_d, ond_q, ond_d, offd_q, offd_d;
    logic [7:0] slew_q, slew_d, phs_q, phs_d, rdata_q, rdata_d;
    logic load_q;

    // Load the nonvolatile image in the first cycle after reset release,
    // since an asynchronous reset may only take constants
    always_comb begin
        act_d = act_q;
        slp_d = slp_q;
        ond_d = ond_q;
        offd_d = offd_q;
        slew_d = slew_q;
        phs_d = phs_q;
        rdata_d = 8'h00;
        if (load_q) begin
            act_d = nvm_image_i[7:0] & RS3_SET_MASK;
            slp_d = nvm_image_i[15:8] & RS3_SET_MASK;
            ond_d = nvm_image_i[23:16] & RS3_DLY_MASK;
            offd_d = nvm_image_i[31:24] & RS3_DLY_MASK;
            slew_d = nvm_image_i[39:32] & RS3_SLEW_MASK;
            phs_d = nvm_image_i[47:40] & RS3_PHASE_MASK;
        end else if (write_i) begin
            case (addr_i)
                RS3_ACTIVE_OFS: act_d = wdata_i & RS3_SET_MASK;
                RS3_SLEEP_OFS: slp_d = wdata_i & RS3_SET_MASK;
                RS3_ON_DLY_OFS: ond_d = wdata_i & RS3_DLY_MASK;
                RS3_OFF_DLY_OFS: offd_d = wdata_i & RS3_DLY_MASK;
                RS3_SLEW_OFS: slew_d = wdata_i & RS3_SLEW_MASK;
                RS3_PHASE_OFS: phs_d = wdata_i & RS3_PHASE_MASK;
                default: ;
            endcase
        end
        if (read_i) begin
            case (addr_i)
                RS3_ACTIVE_OFS: rdata_d = act_q;
                RS3_SLEEP_OFS: rdata_d = slp_q;
                RS3_ON_DLY_OFS: rdata_d = ond_q;
                RS3_OFF_DLY_OFS: rdata_d = offd_q;
                RS3_SLEW_OFS: rdata_d = slew_q;
                RS3_PHASE_OFS: rdata_d = phs_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            load_q <= 1'b1;
            act_q <= RS3_ACTIVE_RST;
            slp_q <= RS3_SLEEP_RST;
            ond_q <= RS3_ON_DLY_RST;
            offd_q <= RS3_OFF_DLY_RST;
            slew_q <= RS3_SLEW_RST;
            phs_q <= RS3_PHASE_RST;
            rdata_q <= 8'h00;
        end else begin
            load_q <= 1'b0;
            act_q <= act_d;
            slp_q <= slp_d;
            ond_q <= ond_d;
            offd_q <= offd_d;
            slew_q <= slew_d;
            phs_q <= phs_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Enable pin synchroniser
    // ------------------------------------------------------------
    logic cen_meta_q, cen_q, cen_prev_q;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cen_meta_q <= 1'b0;
            cen_q <= 1'b0;
            cen_prev_q <= 1'b0;
        end else begin
            cen_meta_q <= chip_enable_input_i;
            cen_q <= cen_meta_q;
            cen_prev_q <= cen_q;
        end
    end

    // ------------------------------------------------------------
    // Sequencing state machine
    // ------------------------------------------------------------
    rs3_state_t state_q, state_d;
    logic start, stop, done, en_q, en_d, stby_q, stby_d, rst_q, rst_d;
    logic [8:0] ticks;

    // Shutdown code to half-millisecond ticks
    function automatic logic [8:0] shut_ticks(input logic [1:0] code);
        case (code)
            2'h0: shut_ticks = RS3_SHUT_4MS;
            2'h1: shut_ticks = RS3_SHUT_2MS;
            2'h2: shut_ticks = RS3_SHUT_1MS;
            default: shut_ticks = RS3_SHUT_0P5MS;
        endcase
    endfunction

    always_comb begin
        state_d = state_q;
        start = 1'b0;
        stop = 1'b0;
        en_d = en_q;
        stby_d = 1'b0;
        rst_d = 1'b0;
        ticks = {1'b0, ond_q[6:0], 1'b0};
        case (state_q)
            RS3_OFF: begin
                if (cen_q && !cen_prev_q) begin
                    state_d = RS3_ON_WAIT;
                    start = 1'b1;
                end
            end
            RS3_ON_WAIT: begin
                ticks = {1'b0, ond_q[6:0], 1'b0};
                if (!cen_q) begin
                    state_d = RS3_OFF;
                    stop = 1'b1;
                end else if (done) begin
                    state_d = RS3_ON;
                    en_d = 1'b1;
                end
            end
            RS3_ON: begin
                if (!cen_q) begin
                    state_d = RS3_OFF_WAIT;
                    start = 1'b1;
                end
            end
            RS3_OFF_WAIT: begin
                ticks = {1'b0, offd_q[6:0], 1'b0};
                if (done) begin
                    state_d = RS3_LAST_WAIT;
                    en_d = 1'b0;
                end
            end
            RS3_LAST_WAIT: begin
                // Period counts from the last rail going off
                if (last_rail_off_i) begin
                    if (shutdown_option_i == RS3_SHUT_OPT_SKIP) begin
                        state_d = RS3_STANDBY;
                    end else begin
                        state_d = RS3_SHUTDOWN;
                        start = 1'b1;
                    end
                end
            end
            RS3_SHUTDOWN: begin
                ticks = shut_ticks(slew_q[RS3_SHUT_LSB +: 2]);
                if (done) begin
                    state_d = RS3_STANDBY;
                end
            end
            RS3_STANDBY: begin
                stby_d = 1'b1;
                state_d = RS3_RESET;
            end
            RS3_RESET: begin
                rst_d = 1'b1;
                state_d = RS3_OFF;
            end
            default: state_d = RS3_OFF;
        endcase
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= RS3_OFF;
            en_q <= 1'b0;
            stby_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            state_q <= state_d;
            en_q <= en_d;
            stby_q <= stby_d;
            rst_q <= rst_d;
        end
    end

    rs3_timer #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) rs3_timer_i (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .start_i(start),
        .stop_i(stop),
        .ticks_i(ticks),
        .done_o(done)
    );

    // ------------------------------------------------------------
    // Rail control outputs
    // ------------------------------------------------------------
    logic [1:0] mode_q, mode_d, soft_q, rup_q, rdn_q, ph_q, ph_d;
    logic [3:0] volt_q, volt_d;

    // Reserved mode codes pass through unchanged; software avoids them
    always_comb begin
        if (sleep_state_i) begin
            mode_d = slp_q[RS3_MODE_LSB +: 2];
            volt_d = slp_q[RS3_VOLT_LSB +: 4];
        end else begin
            mode_d = act_q[RS3_MODE_LSB +: 2];
            volt_d = act_q[RS3_VOLT_LSB +: 4];
        end
        ph_d = rail1_phase_lock_enable_i ? phs_q[RS3_PH_LSB +: 2] : 2'h0;
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q <= RS3_MODE_AUTO;
            volt_q <= 4'h0;
            soft_q <= 2'h0;
            rup_q <= 2'h0;
            rdn_q <= 2'h0;
            ph_q <= 2'h0;
        end else begin
            mode_q <= mode_d;
            volt_q <= volt_d;
            soft_q <= slew_q[RS3_SOFT_LSB +: 2];
            rup_q <= slew_q[RS3_RUP_LSB +: 2];
            rdn_q <= slew_q[RS3_RDN_LSB +: 2];
            ph_q <= ph_d;
        end
    end

    assign rdata_o = rdata_q;
    assign rail3_enable_o = en_q;
    assign rail3_op_mode_o = mode_q;
    assign rail3_voltage_code_o = volt_q;
    assign rail3_soft_start_time_o = soft_q;
    assign rail3_ramp_up_rate_o = rup_q;
    assign rail3_ramp_down_rate_o = rdn_q;
    assign rail3_phase_shift_o = ph_q;
    assign fsm_standby_o = stby_q;
    assign fsm_reset_o = rst_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);

    awake_mode_sel_a: assert property (
        !sleep_state_i |=> rail3_op_mode_o == $past(act_q[5:4]))
        else $error("awake mode not applied");
    awake_volt_sel_a: assert property (
        !sleep_state_i |=> rail3_voltage_code_o == $past(act_q[3:0]))
        else $error("awake voltage not applied");
    sleep_mode_sel_a: assert property (
        sleep_state_i |=> rail3_op_mode_o == $past(slp_q[5:4]))
        else $error("sleep mode not applied");
    sleep_volt_sel_a: assert property (
        sleep_state_i |=> rail3_voltage_code_o == $past(slp_q[3:0]))
        else $error("sleep voltage not applied");
    zero_on_delay_a: assert property (
        (state_q == RS3_OFF && start && ond_q == 8'h00 && !stop) ##1
        (cen_q [*2]) |=> rail3_enable_o)
        else $error("zero turn-on delay not honoured");
    shut_skip_a: assert property (
        (state_q == RS3_LAST_WAIT && last_rail_off_i &&
        shutdown_option_i == 2'h3) |-> ##2 fsm_standby_o)
        else $error("skipped shutdown period did not reach standby");
    standby_then_reset_a: assert property (
        $rose(fsm_standby_o) |=> fsm_reset_o && !fsm_standby_o)
        else $error("standby not followed by reset");
    unused_bits_zero_a: assert property (
        act_q[7:6] == 2'h0 && ond_q[7] == 1'b0 && phs_q[4:0] == 5'h00)
        else $error("unused bits hold ones");
    phase_gate_a: assert property (
        !rail1_phase_lock_enable_i |=> rail3_phase_shift_o == 2'h0)
        else $error("phase shift applied without lock enable");
    ramp_rates_a: assert property (
        ##1 rail3_ramp_up_rate_o == $past(slew_q[3:2]) &&
        rail3_ramp_down_rate_o == $past(slew_q[1:0]))
        else $error("ramp rate codes not forwarded");
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the rail 3 sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin \
    miscompares++; $display("MISMATCH %0t %s", $time, m); end end
module tb_top import rs3_pkg::*;;
    // ------------------------------------------------------------
    // Design and stimulus
    // ------------------------------------------------------------
    // Short tick keeps millisecond counts to a few dozen cycles
    localparam int HALF = 4;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic write_i = 1'b0;
    logic read_i = 1'b0;
    logic [7:0] rdata_o;
    logic [47:0] nvm_image_i = 48'hFF_A5_BC_82_E6_D5;
    logic chip_enable_input_i = 1'b0;
    logic sleep_state_i = 1'b0;
    logic last_rail_off_i = 1'b0;
    logic [1:0] shutdown_option_i = 2'h0;
    logic rail1_phase_lock_enable_i = 1'b0;
    logic rail3_enable_o;
    logic [1:0] rail3_op_mode_o;
    logic [3:0] rail3_voltage_code_o;
    logic [1:0] rail3_soft_start_time_o;
    logic [1:0] rail3_ramp_up_rate_o;
    logic [1:0] rail3_ramp_down_rate_o;
    logic [1:0] rail3_phase_shift_o;
    logic fsm_standby_o;
    logic fsm_reset_o;
    int miscompares = 0;
    int n_compared = 0;

    rs3_sequencer #(.HALF_MS_CYCLES(HALF)) rs3_sequencer_i (
        .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
        .rdata_o(rdata_o), .nvm_image_i(nvm_image_i),
        .chip_enable_input_i(chip_enable_input_i),
        .sleep_state_i(sleep_state_i), .last_rail_off_i(last_rail_off_i),
        .shutdown_option_i(shutdown_option_i),
        .rail1_phase_lock_enable_i(rail1_phase_lock_enable_i),
        .rail3_enable_o(rail3_enable_o), .rail3_op_mode_o(rail3_op_mode_o),
        .rail3_voltage_code_o(rail3_voltage_code_o),
        .rail3_soft_start_time_o(rail3_soft_start_time_o),
        .rail3_ramp_up_rate_o(rail3_ramp_up_rate_o),
        .rail3_ramp_down_rate_o(rail3_ramp_down_rate_o),
        .rail3_phase_shift_o(rail3_phase_shift_o),
        .fsm_standby_o(fsm_standby_o), .fsm_reset_o(fsm_reset_o)
    );

    always #5 clock_i = ~clock_i;

    // ------------------------------------------------------------
    // Bus and wait helpers
    // ------------------------------------------------------------
    task automatic results();
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    // Bounded wait: 0 rail on, 1 rail off, 2 standby pulse
    task automatic wait_out(input int sel, output int n);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit) begin
            @(posedge clock_i);
            #1;
            n++;
            if (n > 3000) begin
                miscompares++;
                $display("MISMATCH %0t wait timed out", $time);
                results();
            end
            hit = (sel == 0) ? (rail3_enable_o === 1'b1) :
                  (sel == 1) ? (rail3_enable_o === 1'b0) :
                  (fsm_standby_o === 1'b1);
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        logic [7:0] d;
        rd(RS3_ACTIVE_OFS, d);
        `CHK(d, 8'h15, "active default")
        rd(RS3_SLEEP_OFS, d);
        `CHK(d, 8'h26, "sleep default")
        rd(RS3_ON_DLY_OFS, d);
        `CHK(d, 8'h02, "on delay default")
        rd(RS3_OFF_DLY_OFS, d);
        `CHK(d, 8'h3C, "off delay default")
        rd(RS3_SLEW_OFS, d);
        `CHK(d, 8'hA5, "slew default")
        rd(RS3_PHASE_OFS, d);
        `CHK(d, 8'h60, "phase default")
        @(posedge clock_i);
        #1;
        `CHK(rdata_o, 8'h00, "read data not cleared")
        `CHK(rail3_op_mode_o, 2'h1, "awake mode")
        `CHK(rail3_voltage_code_o, 4'h5, "awake voltage")
        `CHK(rail3_soft_start_time_o, 2'h2, "soft start")
    endtask

    task automatic t_masks();
        logic [7:0] d;
        logic [7:0] ofs[6];
        logic [7:0] msk[6];
        logic [7:0] dat[6];
        ofs = '{RS3_ACTIVE_OFS, RS3_SLEEP_OFS, RS3_ON_DLY_OFS,
                RS3_OFF_DLY_OFS, RS3_SLEW_OFS, RS3_PHASE_OFS};
        // Mode fields get a legal code while the unused bits are set
        dat = '{8'hDF, 8'hDF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        msk = '{8'h1F, 8'h1F, 8'h7F, 8'h7F, 8'hFF, 8'h60};
        for (int i = 0; i < 6; i++) begin
            wr(ofs[i], dat[i]);
            rd(ofs[i], d);
            `CHK(d, msk[i], "unused bits")
        end
        wr(8'h35, 8'hAA);
        rd(8'h35, d);
        `CHK(d, 8'h00, "unmapped read")
        rd(8'h2E, d);
        `CHK(d, 8'h00, "unmapped below")
    endtask

    // Reserved mode codes are left out on purpose
    task automatic t_modes();
        for (int m = 0; m < 2; m++) begin
            wr(RS3_ACTIVE_OFS, 8'(m * 16 + 3 + m));
            wr(RS3_SLEEP_OFS, 8'((1 - m) * 16 + 9 + m));
            sleep_state_i <= 1'b0;
            repeat (3) @(posedge clock_i);
            #1;
            `CHK(rail3_op_mode_o, 2'(m), "awake mode sel")
            `CHK(rail3_voltage_code_o, 4'(3 + m), "awake volt")
            @(posedge clock_i);
            sleep_state_i <= 1'b1;
            repeat (3) @(posedge clock_i);
            #1;
            `CHK(rail3_op_mode_o, 2'(1 - m), "sleep mode sel")
            `CHK(rail3_voltage_code_o, 4'(9 + m), "sleep volt")
        end
        sleep_state_i <= 1'b0;
    endtask

    task automatic t_slew_phase();
        for (int i = 0; i < 4; i++) begin
            wr(RS3_SLEW_OFS, {2'(i), 2'b00, 2'(i), 2'(3 - i)});
            wr(RS3_PHASE_OFS, {1'b0, 2'(i), 5'h1F});
            rail1_phase_lock_enable_i <= 1'b1;
            repeat (3) @(posedge clock_i);
            #1;
            `CHK(rail3_soft_start_time_o, 2'(i), "soft start")
            `CHK(rail3_ramp_up_rate_o, 2'(i), "ramp up")
            `CHK(rail3_ramp_down_rate_o, 2'(3 - i), "ramp down")
            `CHK(rail3_phase_shift_o, 2'(i), "phase locked")
            @(posedge clock_i);
            rail1_phase_lock_enable_i <= 1'b0;
            repeat (3) @(posedge clock_i);
            #1;
            `CHK(rail3_phase_shift_o, 2'h0, "phase unlocked")
        end
    endtask

    task automatic t_seq(input logic [1:0] opt, input logic [1:0] code,
                         input int lo, input int hi);
        int n;
        int pulses;
        wr(RS3_SLEW_OFS, {2'b00, code, 4'h0});
        shutdown_option_i <= opt;
        chip_enable_input_i <= 1'b1;
        wait_out(0, n);
        `CHK(n >= 8 && n <= 22, 1'b1, "turn-on delay")
        @(posedge clock_i);
        chip_enable_input_i <= 1'b0;
        wait_out(1, n);
        `CHK(n >= 8 && n <= 22, 1'b1, "turn-off delay")
        pulses = 0;
        repeat (50) begin
            @(posedge clock_i);
            #1;
            pulses += (fsm_standby_o !== 1'b0);
        end
        `CHK(pulses, 0, "period began before last rail off")
        @(posedge clock_i);
        last_rail_off_i <= 1'b1;
        wait_out(2, n);
        `CHK(n >= lo && n <= hi, 1'b1, "shutdown period")
        @(posedge clock_i);
        #1;
        `CHK({fsm_standby_o, fsm_reset_o}, 2'b01, "standby order")
        @(posedge clock_i);
        last_rail_off_i <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask

    task automatic t_abort();
        int highs;
        wr(RS3_ON_DLY_OFS, 8'h04);
        chip_enable_input_i <= 1'b1;
        repeat (12) @(posedge clock_i);
        chip_enable_input_i <= 1'b0;
        highs = 0;
        repeat (60) begin
            @(posedge clock_i);
            #1;
            highs += (rail3_enable_o !== 1'b0);
        end
        `CHK(highs, 0, "rail came on after abort")
    endtask

    // Zero delay: rail comes on three cycles after the synchronised enable edge
    task automatic t_zero();
        int n;
        wr(RS3_ON_DLY_OFS, 8'h00);
        chip_enable_input_i <= 1'b1;
        wait_out(0, n);
        `CHK(n >= 3 && n <= 6, 1'b1, "zero turn-on delay")
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        t_defaults();
        t_masks();
        t_modes();
        t_slew_phase();
        wr(RS3_ON_DLY_OFS, 8'h01);
        wr(RS3_OFF_DLY_OFS, 8'h01);
        t_seq(2'h0, 2'h0, 32, 44);
        t_seq(2'h0, 2'h1, 16, 28);
        t_seq(2'h1, 2'h2, 8, 20);
        t_seq(2'h2, 2'h3, 4, 12);
        // Option 11 skips the period entirely
        t_seq(2'h3, 2'h0, 1, 6);
        t_abort();
        t_zero();
        results();
    end
endmodule
`default_nettype wire
